// ---- ilct_timing.v ----
/*
 * Instruction length and cycle timing: looks up byte length and execution
 * cycle count of a decoded instruction class and holds off the next fetch
 * until that many core clock cycles have passed.
 * Assumes class_in and start_in come from the fetch unit on mclk_in.
 */
`timescale 1ns/1ps
`include "ilct_defs.vh"

module ilct_timing (
    input  wire                   mclk_in,
    input  wire                   rst_in,
    input  wire                   start_in,
    input  wire [`ILCT_CLS_W-1:0] class_in,
    output wire                   ready_out,
    output wire                   busy_out,
    output wire                   valid_out,
    output wire [`ILCT_LEN_W-1:0] len_out,
    output wire [`ILCT_CYC_W-1:0] cycles_out,
    output wire                   ext_out,
    output wire                   ext16_out,
    output wire                   done_out,
    output wire                   bad_out
);

    // ==========================================================
    // States
    localparam ST_IDLE = `ILCT_ST_IDLE;
    localparam ST_EXEC = `ILCT_ST_EXEC;

    // ==========================================================
    // Class lookup
    reg [`ILCT_LEN_W-1:0] lut_len;
    reg [`ILCT_CYC_W-1:0] lut_cyc;
    reg                   lut_known;
    reg                   lut_ext;
    reg                   lut_ext16;

    // Flags mark external moves and their address width
    always @* begin
        lut_len   = 2'd1;
        lut_cyc   = 3'd1;
        lut_known = 1'b1;
        lut_ext   = 1'b0;
        lut_ext16 = 1'b0;
        case (class_in)
            // Rotates
            `ILCT_C_RLC, `ILCT_C_RR, `ILCT_C_RRC: begin
                lut_len = 2'd1;
                lut_cyc = 3'd1;
            end
            // Data transfer
            `ILCT_C_MOV_A_BR, `ILCT_C_MOV_BR_A: begin
                lut_len = 2'd1;
                lut_cyc = 3'd1;
            end
            `ILCT_C_MOV_A_IND: begin
                lut_len = 2'd1;
                lut_cyc = 3'd2;
            end
            `ILCT_C_MOV_IND_A: begin
                lut_len = 2'd1;
                lut_cyc = 3'd2;
            end
            `ILCT_C_MOV_A_DIR: begin
                lut_len = 2'd2;
                lut_cyc = 3'd2;
            end
            `ILCT_C_MOV_A_IMM: begin
                lut_len = 2'd2;
                lut_cyc = 3'd2;
            end
            `ILCT_C_MOV_BR_IM: begin
                lut_len = 2'd2;
                lut_cyc = 3'd2;
            end
            `ILCT_C_MOV_DIR_A: begin
                lut_len = 2'd2;
                lut_cyc = 3'd2;
            end
            `ILCT_C_MOV_BR_DI, `ILCT_C_MOV_DI_BR: begin
                lut_len = 2'd2;
                lut_cyc = 3'd2;
            end
            `ILCT_C_MOV_IND_I: begin
                lut_len = 2'd2;
                lut_cyc = 3'd2;
            end
            `ILCT_C_MOV_DI_IN, `ILCT_C_MOV_IN_DI: begin
                lut_len = 2'd2;
                lut_cyc = 3'd2;
            end
            `ILCT_C_MOV_DI_DI: begin
                lut_len = 2'd3;
                lut_cyc = 3'd3;
            end
            `ILCT_C_MOV_DI_IM: begin
                lut_len = 2'd3;
                lut_cyc = 3'd3;
            end
            `ILCT_C_MOV_DP_IM: begin
                lut_len = 2'd3;
                lut_cyc = 3'd3;
            end
            // Code and external memory
            `ILCT_C_CODE_DP, `ILCT_C_CODE_PC: begin
                lut_len = 2'd1;
                lut_cyc = 3'd4;
            end
            `ILCT_C_EXT_RD8, `ILCT_C_EXT_WR8: begin
                lut_len   = 2'd1;
                lut_cyc   = 3'd4;
                lut_ext   = 1'b1;
                lut_ext16 = 1'b0;
            end
            `ILCT_C_EXT_RD16, `ILCT_C_EXT_WR16: begin
                lut_len   = 2'd1;
                lut_cyc   = 3'd4;
                lut_ext   = 1'b1;
                lut_ext16 = 1'b1;
            end
            // Stack and exchanges
            `ILCT_C_PUSH: begin
                lut_len = 2'd2;
                lut_cyc = 3'd2;
            end
            `ILCT_C_POP: begin
                lut_len = 2'd2;
                lut_cyc = 3'd2;
            end
            `ILCT_C_XCH_BR: begin
                lut_len = 2'd1;
                lut_cyc = 3'd1;
            end
            `ILCT_C_XCH_IND, `ILCT_C_NIB_XCH: begin
                lut_len = 2'd1;
                lut_cyc = 3'd2;
            end
            `ILCT_C_XCH_DIR: begin
                lut_len = 2'd2;
                lut_cyc = 3'd2;
            end
            // Boolean
            `ILCT_C_CLR_C, `ILCT_C_SET_C, `ILCT_C_CPL_C: begin
                lut_len = 2'd1;
                lut_cyc = 3'd1;
            end
            `ILCT_C_CLR_BIT, `ILCT_C_SET_BIT, `ILCT_C_CPL_BIT: begin
                lut_len = 2'd2;
                lut_cyc = 3'd2;
            end
            `ILCT_C_AND_C, `ILCT_C_AND_C_INV: begin
                lut_len = 2'd2;
                lut_cyc = 3'd2;
            end
            `ILCT_C_OR_C, `ILCT_C_OR_C_INV: begin
                lut_len = 2'd2;
                lut_cyc = 3'd2;
            end
            `ILCT_C_MOV_C_BIT, `ILCT_C_MOV_BIT_C: begin
                lut_len = 2'd2;
                lut_cyc = 3'd2;
            end
            // Branching
            `ILCT_C_JMP_IND: begin
                lut_len = 2'd1;
                lut_cyc = 3'd3;
            end
            `ILCT_C_ABS_CALL, `ILCT_C_ABS_JMP: begin
                lut_len = 2'd2;
                lut_cyc = 3'd3;
            end
            `ILCT_C_SUB_RET, `ILCT_C_INT_RET: begin
                lut_len = 2'd1;
                lut_cyc = 3'd4;
            end
            default: begin
                // Unknown class reports zero length and zero cycles
                lut_len   = 2'd0;
                lut_cyc   = 3'd0;
                lut_known = 1'b0;
            end
        endcase
    end

    // ==========================================================
    // Sequencer hold-off
    reg                   state_q;
    reg                   state_d;
    reg [`ILCT_CYC_W-1:0] cnt_q;
    reg [`ILCT_CYC_W-1:0] cnt_d;
    reg                   ready_q;
    reg                   ready_d;
    reg                   valid_q;
    reg                   valid_d;
    reg [`ILCT_LEN_W-1:0] len_q;
    reg [`ILCT_LEN_W-1:0] len_d;
    reg [`ILCT_CYC_W-1:0] cyc_q;
    reg [`ILCT_CYC_W-1:0] cyc_d;
    reg                   ext_q;
    reg                   ext_d;
    reg                   ext16_q;
    reg                   ext16_d;
    reg                   done_q;
    reg                   done_d;
    reg                   bad_q;
    reg                   bad_d;
    wire                  take_w;
    wire                  last_w;

    // Requests are only taken while idle with ready high
    assign take_w = start_in && ready_q && (state_q == ST_IDLE);
    assign last_w = (cnt_q == {`ILCT_CYC_W{1'b0}});

    always @* begin
        state_d = state_q;
        cnt_d   = cnt_q;
        ready_d = ready_q;
        valid_d = valid_q;
        len_d   = len_q;
        cyc_d   = cyc_q;
        ext_d   = ext_q;
        ext16_d = ext16_q;
        done_d  = 1'b0;
        bad_d   = 1'b0;
        case (state_q)
            ST_IDLE: begin
                if (take_w) begin
                    if (lut_known) begin
                        // Ready drops for exactly the listed cycle count
                        state_d = `ILCT_ST_EXEC;
                        cnt_d   = lut_cyc - 3'd1;
                        ready_d = 1'b0;
                        valid_d = 1'b1;
                        len_d   = lut_len;
                        cyc_d   = lut_cyc;
                        ext_d   = lut_ext;
                        ext16_d = lut_ext16;
                    end else begin
                        // Unknown class is refused; the fetch may go on
                        bad_d   = 1'b1;
                        valid_d = 1'b0;
                    end
                end
            end
            ST_EXEC: begin
                // Requests seen while busy are ignored
                if (last_w) begin
                    state_d = `ILCT_ST_IDLE;
                    ready_d = 1'b1;
                    done_d  = 1'b1;
                end else begin
                    cnt_d = cnt_q - 3'd1;
                end
            end
            default: begin
                state_d = ST_IDLE;
                ready_d = 1'b1;
            end
        endcase
    end

    // Synchronous reset leaves the block idle with ready high
    always @(posedge mclk_in) begin
        if (rst_in) begin
            state_q <= ST_IDLE;
            cnt_q   <= {`ILCT_CYC_W{1'b0}};
            ready_q <= `ILCT_RST_READY;
            valid_q <= 1'b0;
            len_q   <= {`ILCT_LEN_W{1'b0}};
            cyc_q   <= {`ILCT_CYC_W{1'b0}};
            ext_q   <= 1'b0;
            ext16_q <= 1'b0;
            done_q  <= 1'b0;
            bad_q   <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            ready_q <= ready_d;
            valid_q <= valid_d;
            len_q   <= len_d;
            cyc_q   <= cyc_d;
            ext_q   <= ext_d;
            ext16_q <= ext16_d;
            done_q  <= done_d;
            bad_q   <= bad_d;
        end
    end

    // ==========================================================
    // Outputs
    // Each output is driven straight from a flip-flop
    assign ready_out  = ready_q;
    assign busy_out   = state_q;
    assign valid_out  = valid_q;
    assign len_out    = len_q;
    assign cycles_out = cyc_q;
    assign ext_out    = ext_q;
    assign ext16_out  = ext16_q;
    assign done_out   = done_q;
    assign bad_out    = bad_q;

endmodule

// ---- ilct_defs.vh ----
/*
 * Constants for the instruction length and cycle timing block: class codes of
 * the decoded instruction subset, field widths and the reset state.
 * Assumes the fetch unit has already reduced each opcode to one class code.
 */
//
// Summary of operation
// - Accumulator rotates: one byte, one cycle
// - Accumulator with indirect memory: one byte, two cycles
// - Two-byte move forms take two cycles
// - Three-byte move forms take three cycles
// - Code memory reads: one byte, four cycles
// - External data moves: one byte, four cycles
// - Stack push and pop: two bytes, two cycles
// - Exchanges: register 1/1, indirect 1/2, direct 2/2
// - Carry ops 1/1, direct bit ops 2/2
// - Indirect jump: one byte, three cycles
// - Absolute call/jump 2/3, returns 1/4
`ifndef ILCT_DEFS_VH
`define ILCT_DEFS_VH

`define ILCT_CLS_W       6
`define ILCT_LEN_W       2
`define ILCT_CYC_W       3
`define ILCT_ST_IDLE     1'b0
`define ILCT_ST_EXEC     1'b1
`define ILCT_RST_READY   1'b1

`define ILCT_C_RLC       6'h00
`define ILCT_C_RR        6'h01
`define ILCT_C_RRC       6'h02
`define ILCT_C_MOV_A_BR  6'h03
`define ILCT_C_MOV_BR_A  6'h04
`define ILCT_C_MOV_A_IND 6'h05
`define ILCT_C_MOV_IND_A 6'h06
`define ILCT_C_MOV_A_DIR 6'h07
`define ILCT_C_MOV_A_IMM 6'h08
`define ILCT_C_MOV_BR_IM 6'h09
`define ILCT_C_MOV_DIR_A 6'h0a
`define ILCT_C_MOV_BR_DI 6'h0b
`define ILCT_C_MOV_DI_BR 6'h0c
`define ILCT_C_MOV_IND_I 6'h0d
`define ILCT_C_MOV_DI_IN 6'h0e
`define ILCT_C_MOV_IN_DI 6'h0f
`define ILCT_C_MOV_DI_DI 6'h10
`define ILCT_C_MOV_DI_IM 6'h11
`define ILCT_C_MOV_DP_IM 6'h12
`define ILCT_C_CODE_DP   6'h13
`define ILCT_C_CODE_PC   6'h14
`define ILCT_C_EXT_RD8   6'h15
`define ILCT_C_EXT_RD16  6'h16
`define ILCT_C_EXT_WR8   6'h17
`define ILCT_C_EXT_WR16  6'h18
`define ILCT_C_PUSH      6'h19
`define ILCT_C_POP       6'h1a
`define ILCT_C_XCH_BR    6'h1b
`define ILCT_C_XCH_IND   6'h1c
`define ILCT_C_NIB_XCH   6'h1d
`define ILCT_C_XCH_DIR   6'h1e
`define ILCT_C_CLR_C     6'h1f
`define ILCT_C_SET_C     6'h20
`define ILCT_C_CPL_C     6'h21
`define ILCT_C_CLR_BIT   6'h22
`define ILCT_C_SET_BIT   6'h23
`define ILCT_C_CPL_BIT   6'h24
`define ILCT_C_AND_C     6'h25
`define ILCT_C_AND_C_INV 6'h26
`define ILCT_C_OR_C      6'h27
`define ILCT_C_OR_C_INV  6'h28
`define ILCT_C_MOV_C_BIT 6'h29
`define ILCT_C_MOV_BIT_C 6'h2a
`define ILCT_C_JMP_IND   6'h2b
`define ILCT_C_ABS_CALL  6'h2c
`define ILCT_C_ABS_JMP   6'h2d
`define ILCT_C_SUB_RET   6'h2e
`define ILCT_C_INT_RET   6'h2f

`endif

// ---- ilct_timing_assertions.sv ----
/*
 * Checker for the instruction length and cycle timing block.
 * Assumes one clock mclk_in and a synchronous active-high rst_in.
 */
`timescale 1ns/1ps

module ilct_timing_chk (
    input wire logic       mclk_in,
    input wire logic       rst_in,
    input wire logic       start_in,
    input wire logic [5:0] class_in,
    input wire logic       ready_out,
    input wire logic       busy_out,
    input wire logic       valid_out,
    input wire logic [1:0] len_out,
    input wire logic [2:0] cycles_out,
    input wire logic       ext_out,
    input wire logic       ext16_out,
    input wire logic       done_out,
    input wire logic       bad_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);

    wire      take_w  = start_in && ready_out;
    wire      known_w = class_in < 6'h30;
    reg [2:0] cnt_q;

    // ==========================================
    // Hold-off counter
    always @(posedge mclk_in) begin
        if (rst_in || ready_out)
            cnt_q <= 3'h0;
        else
            cnt_q <= cnt_q + 3'h1;
    end

    // ==========================================
    // Assertions
    AST_TAKE: assert property (take_w && known_w |=> !ready_out && busy_out && valid_out)
        else $error("known class not taken");
    AST_REFUSE: assert property (take_w && !known_w |=>
        bad_out && ready_out && !valid_out)
        else $error("unknown class not refused");
    AST_BUSY: assert property (busy_out != ready_out)
        else $error("busy and ready disagree");
    AST_HOLD: assert property ($rose(ready_out) |-> done_out && cnt_q == cycles_out)
        else $error("hold-off length wrong");
    AST_NO_OVER: assert property (!ready_out |-> cnt_q < cycles_out)
        else $error("hold-off overran");
    AST_DONE: assert property (done_out |-> ready_out && !$past(ready_out))
        else $error("stray done pulse");
    AST_IGNORE: assert property (!ready_out |=>
        $stable(len_out) && $stable(cycles_out) && !bad_out)
        else $error("request taken while busy");
    AST_SHORT: assert property (take_w && class_in <= 6'h04 |=>
        len_out == 2'h1 && cycles_out == 3'h1)
        else $error("rotate or register move timing wrong");
    AST_THREE: assert property (take_w && class_in >= 6'h10 && class_in <= 6'h12 |=>
        len_out == 2'h3 && cycles_out == 3'h3)
        else $error("three byte move timing wrong");
    AST_EXT: assert property (take_w && class_in >= 6'h15 && class_in <= 6'h18 |=>
        ext_out && ext16_out == !$past(class_in[0]) && cycles_out == 3'h4)
        else $error("external move flags wrong");
    AST_RET: assert property (take_w && class_in >= 6'h2e && class_in <= 6'h2f |=>
        len_out == 2'h1 && cycles_out == 3'h4)
        else $error("return timing wrong");

    COV_RET: cover property (take_w && class_in == 6'h2e ##5 done_out);
    COV_BAD: cover property (take_w && !known_w ##1 bad_out);
    COV_EXT16: cover property (ext_out && ext16_out);
    COV_CLASH: cover property (start_in && !ready_out ##1 !ready_out && !bad_out);
endmodule

bind ilct_timing ilct_timing_chk u_chk (.mclk_in(mclk_in), .rst_in(rst_in), .start_in(start_in),
    .class_in(class_in), .ready_out(ready_out), .busy_out(busy_out), .valid_out(valid_out),
    .len_out(len_out), .cycles_out(cycles_out), .ext_out(ext_out), .ext16_out(ext16_out),
    .done_out(done_out), .bad_out(bad_out));

// ---- ilct_fetch_model.sv ----
/*
 * Model of the fetch unit that issues instruction classes to the timing block.
 * Assumes the bench raises go_in for one cycle per instruction.
 */
`timescale 1ns/1ps

module ilct_fetch_model (
    input  wire       mclk_in,
    input  wire       rst_in,
    input  wire       ready_in,
    input  wire       go_in,
    input  wire       bypass_in,
    input  wire [5:0] code_in,
    output reg        start_out = 1'b0,
    output reg  [5:0] class_out = 6'h2a
);
    // ==========================================
    // Issue only while the sequencer may fetch or bypass_in is set; code scrambles when idle
    always @(posedge mclk_in) begin
        if (rst_in) begin
            start_out <= 1'b0;
            class_out <= 6'h2a;
        end else begin
            // Bypass lets the bench present a request while the sequencer is busy
            start_out <= go_in & (ready_in | bypass_in);
            class_out <= go_in ? code_in : ~class_out;
        end
    end
endmodule

// ---- instruction_length_cycle_timing_bench.sv ----
/*
 * Self-checking bench for the instruction length and cycle timing block.
 * Assumes a 40 MHz clock and the fetch model as the requesting party.
 */
`timescale 1ns/1ps

module instruction_length_cycle_timing_bench;
    reg         mclk_in     = 1'b0;
    reg         rst_in      = 1'b1;
    reg         go_q        = 1'b0;
    reg  [5:0]  code_q      = 6'h00;
    reg  [31:0] seed        = 32'h81bf0c36;
    reg         bypass_q    = 1'b0;
    wire        start_w, ready_w, busy_w, valid_w, ext_w, ext16_w, done_w, bad_w;
    wire [5:0]  class_w;
    wire [1:0]  len_w;
    wire [2:0]  cyc_w;
    integer     fail_count  = 0;
    integer     checks_done = 0;
    integer     hung        = 0;
    integer     n;
    integer     i;

    always #12.5 mclk_in = ~mclk_in;

    ilct_fetch_model fetch (.mclk_in(mclk_in), .rst_in(rst_in), .ready_in(ready_w),
        .go_in(go_q), .bypass_in(bypass_q), .code_in(code_q), .start_out(start_w),
        .class_out(class_w));
    ilct_timing dut (.mclk_in(mclk_in), .rst_in(rst_in), .start_in(start_w),
        .class_in(class_w), .ready_out(ready_w), .busy_out(busy_w), .valid_out(valid_w),
        .len_out(len_w), .cycles_out(cyc_w), .ext_out(ext_w), .ext16_out(ext16_w),
        .done_out(done_w), .bad_out(bad_w));

    // ==========================================
    // Reference model: {length, cycles}, zero for unknown classes
    function [4:0] expect_of(input [5:0] c);
        if (c <= 6'h04 || c == 6'h1b || (c >= 6'h1f && c <= 6'h21))
            expect_of = {2'h1, 3'h1};
        else if (c <= 6'h06 || c == 6'h1c || c == 6'h1d)
            expect_of = {2'h1, 3'h2};
        else if (c <= 6'h0f)
            expect_of = {2'h2, 3'h2};
        else if (c <= 6'h12)
            expect_of = {2'h3, 3'h3};
        else if (c <= 6'h18 || c >= 6'h2e && c <= 6'h2f)
            expect_of = {2'h1, 3'h4};
        else if (c == 6'h2b)
            expect_of = {2'h1, 3'h3};
        else if (c == 6'h2c || c == 6'h2d)
            expect_of = {2'h2, 3'h3};
        else if (c <= 6'h2a)
            expect_of = {2'h2, 3'h2};
        else
            expect_of = 5'h00;
    endfunction

    function [31:0] xorshift(input [31:0] s);
        reg [31:0] t;
        begin
            t = s ^ (s << 13);
            t = t ^ (t >> 17);
            xorshift = t ^ (t << 5);
        end
    endfunction

    // ==========================================
    // Compare tasks and verdict
    task check_val(input [31:0] got, input [31:0] want, input [8*12:1] what);
        begin
            checks_done = checks_done + 1;
            if (got !== want) begin
                fail_count = fail_count + 1;
                $display("unexpected at %0t: %0s got %0h want %0h", $time, what, got, want);
            end
        end
    endtask

    task check_flag(input got, input want, input [8*12:1] what);
        begin
            check_val({31'h0, got}, {31'h0, want}, what);
        end
    endtask

    task close_out;
        begin
            $display("checks %0d mismatches %0d", checks_done, fail_count);
            if (fail_count == 0 && checks_done > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask

    // ==========================================
    // One instruction through fetch model and timing block
    task run_one(input [5:0] c);
        reg [4:0] e;
        begin
            e = expect_of(c);
            @(posedge mclk_in);
            go_q   <= 1'b1;
            code_q <= c;
            @(posedge mclk_in);
            go_q <= 1'b0;
            @(posedge mclk_in);
            #1;
            if (e == 5'h00) begin
                check_flag(bad_w, 1'b1, "bad pulse");
                check_flag(ready_w, 1'b1, "ready kept");
                check_flag(valid_w, 1'b0, "valid clear");
                check_flag(busy_w, 1'b0, "no busy");
            end else begin
                check_val(len_w, e[4:3], "length");
                check_val(cyc_w, e[2:0], "cycles");
                check_flag(valid_w, 1'b1, "valid set");
                check_flag(busy_w, 1'b1, "busy set");
                check_flag(ext_w, c >= 6'h15 && c <= 6'h18, "ext");
                if (c >= 6'h15 && c <= 6'h18) begin
                    check_flag(ext16_w, ~c[0], "ext16");
                end
                n = 0;
                while (ready_w !== 1'b1 && n < 8) begin
                    @(posedge mclk_in);
                    #1;
                    n = n + 1;
                end
                if (n == 8)
                    hung = 1;
                check_val(n, e[2:0], "hold-off");
                check_flag(done_w, 1'b1, "done");
                check_flag(busy_w, 1'b0, "busy clear");
            end
        end
    endtask

    // ==========================================
    // A second request while a four-cycle return is running
    task run_clash;
        begin
            @(posedge mclk_in);
            go_q   <= 1'b1;
            code_q <= 6'h2e;
            @(posedge mclk_in);
            code_q   <= 6'h00;
            bypass_q <= 1'b1;
            @(posedge mclk_in);
            go_q     <= 1'b0;
            bypass_q <= 1'b0;
            @(posedge mclk_in);
            #1;
            check_val(len_w, 2'h1, "busy length");
            check_val(cyc_w, 3'h4, "busy cycles");
            check_flag(bad_w, 1'b0, "busy no bad");
            n = 0;
            while (ready_w !== 1'b1 && n < 8) begin
                @(posedge mclk_in);
                #1;
                n = n + 1;
            end
            if (n == 8)
                hung = 1;
            check_val(n, 3, "busy hold");
        end
    endtask

    // ==========================================
    // Main sequence
    initial begin
        repeat (12) @(posedge mclk_in);
        rst_in <= 1'b0;
        @(posedge mclk_in);
        #1;
        check_flag(ready_w, 1'b1, "reset ready");
        check_val(len_w, 2'h0, "reset len");
        check_flag(busy_w, 1'b0, "reset busy");
        check_flag(valid_w, 1'b0, "reset valid");
        $display("reset test done");
        for (i = 0; i < 25 && hung == 0; i = i + 1)
            run_one(i[5:0]);
        for (i = 25; i < 48 && hung == 0; i = i + 1)
            run_one(i[5:0]);
        $display("class sweep done");
        if (hung == 0)
            run_clash;
        $display("clash test done");
        for (i = 0; i < 40 && hung == 0; i = i + 1) begin
            seed = xorshift(seed);
            run_one(seed[5:0]);
        end
        $display("random test done");
        close_out;
    end
endmodule
